// ---- pkg/txt_regs.vh ----
`ifndef TXT_REGS_VH
`define TXT_REGS_VH

// register indices; byte address is four times the index
`define TXT_IDX_PROTO 6'h01
`define TXT_IDX_TIMER_HI 6'h04
`define TXT_IDX_TIMER_LO 6'h05
`define TXT_IDX_PULSE 6'h06
`define TXT_IDX_STATUS 6'h0b
`define TXT_IDX_COUNT_LO 6'h0c
`define TXT_IDX_COUNT_HI 6'h0d

// reset and preset values
`define TXT_PROTO_RESET 8'h00
`define TXT_TIMER_HI_RESET 8'hc2
`define TXT_TIMER_LO_RESET 8'h00
`define TXT_PULSE_RESET 8'h00

// field positions
`define TXT_SEL_MSB 7
`define TXT_SEL_LSB 6
`define TXT_LEN_HI_MSB 5
`define TXT_PROTO_MSB 2
`define TXT_ST_RUN 0
`define TXT_ST_PULSE 1
`define TXT_ST_EN 2

// start selector codes
`define TXT_SEL_TX_BEGIN 2'h0
`define TXT_SEL_TX_END 2'h1
`define TXT_SEL_RX_BEGIN 2'h2
`define TXT_SEL_RX_END 2'h3

// protocol codes
`define TXT_PROTO_VIC 3'h0
`define TXT_PROTO_A106 3'h1
`define TXT_PROTO_A212 3'h2
`define TXT_PROTO_A424 3'h3
`define TXT_PROTO_A848 3'h4

// timing, clock 50 MHz; least times round up
`define TXT_CLK_MHZ 50
`define TXT_TICK_NS 590
`define TXT_TICK_CYC ((`TXT_TICK_NS * `TXT_CLK_MHZ + 999) / 1000)
`define TXT_STEP_DNS 737
`define TXT_STEP_CYC ((`TXT_STEP_DNS * `TXT_CLK_MHZ + 9999) / 10000)
`define TXT_VIC_NS 9440
`define TXT_A106_NS 2360
`define TXT_A212_NS 1400
`define TXT_A424_NS 737
`define TXT_NS2CYC(ns) (((ns) * `TXT_CLK_MHZ + 999) / 1000)

`endif

// ---- hw/txt_pulse_gen.v ----
`timescale 1ns/100ps
module txt_pulse_gen (
    input wire clk_i,
    input wire rst_i,
    input wire clear_i,
    input wire start_i,
    input wire bypass_i,
    input wire level_i,
    input wire [9:0] width_i,
    output reg pulse_o
);

reg [9:0] count_r;

always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
        pulse_o <= 1'b0;
        count_r <= 10'h000;
    end else if (bypass_i) begin
        // no width control: modulation follows level_i, not the start request
        pulse_o <= level_i;
        count_r <= 10'h000;
    end else if (start_i && width_i != 10'h000) begin
        pulse_o <= 1'b1;
        count_r <= width_i - 10'h001;
    end else if (count_r != 10'h000) begin
        count_r <= count_r - 10'h001;
    end else begin
        pulse_o <= 1'b0;
    end
end

endmodule

// ---- hw/txt_delay_timer.v ----
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "txt_regs.vh"
// Notes on behaviour
// - selector bits pick one of four start events
// - 14-bit length, 590 ns per unit
// - zero length disables the delay timer
// - length sets trigger time after start event
// - high timer register defaults to c2
// - low timer register defaults to zero
// - protocol write reloads both timer registers
// - zero override uses the protocol pulse width
// - nonzero override sets width times 73.7 ns
// - override cleared by reset, enable, protocol write
// - protocol widths 9.44, 2.36, 1.4 us, 737 ns
module txt_delay_timer (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_stb_i,
    input wire wb_cyc_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire en_i,
    input wire tx_sof_begin_i,
    input wire tx_sof_end_i,
    input wire rx_sof_begin_i,
    input wire rx_sof_end_i,
    input wire mod_req_i,
    input wire mod_level_i,
    output reg tx_trigger_o,
    output reg timer_busy_o,
    output wire mod_pulse_o
);

// counts round up; cut on purpose to the counter widths
localparam integer TICK_LAST_I = `TXT_TICK_CYC - 1;
localparam integer STEP_I = `TXT_STEP_CYC;
localparam integer VIC_I = `TXT_NS2CYC(`TXT_VIC_NS);
localparam integer A106_I = `TXT_NS2CYC(`TXT_A106_NS);
localparam integer A212_I = `TXT_NS2CYC(`TXT_A212_NS);
localparam integer A424_I = `TXT_NS2CYC(`TXT_A424_NS);
localparam [4:0] TICK_LAST = TICK_LAST_I[4:0];
localparam [9:0] STEP_CYC = STEP_I[9:0];
localparam [9:0] VIC_CYC = VIC_I[9:0];
localparam [9:0] A106_CYC = A106_I[9:0];
localparam [9:0] A212_CYC = A212_I[9:0];
localparam [9:0] A424_CYC = A424_I[9:0];

function hit;
    input [5:0] idx;
    input [5:0] target;
    begin
        hit = (idx == target);
    end
endfunction

// enable pin synchroniser
reg en_s1_r;
reg en_s2_r;
reg en_s3_r;
reg en_r;

always @(posedge clk_i) begin
    if (rst_i) begin
        en_s1_r <= 1'b0;
        en_s2_r <= 1'b0;
        en_s3_r <= 1'b0;
        en_r <= 1'b0;
    end else begin
        en_s1_r <= en_i;
        en_s2_r <= en_s1_r;
        en_s3_r <= en_s2_r;
        // a change counts only once the last two stages agree
        if (en_s2_r == en_s3_r) begin
            en_r <= en_s3_r;
        end
    end
end

wire preset = ~en_r;

// bus decode
wire [5:0] idx = wb_adr_i[7:2];
wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
// only byte lane 0 carries register bits; other lanes are dropped
wire wr = req && wb_we_i && wb_sel_i[0];
wire rd = req && !wb_we_i;
wire wr_proto = wr && hit(idx, `TXT_IDX_PROTO);
wire wr_hi = wr && hit(idx, `TXT_IDX_TIMER_HI);
wire wr_lo = wr && hit(idx, `TXT_IDX_TIMER_LO);
wire wr_pulse = wr && hit(idx, `TXT_IDX_PULSE);

// registers
reg [7:0] proto_r;
reg [7:0] timer_hi_r;
reg [7:0] timer_lo_r;
reg [7:0] pulse_r;

always @(posedge clk_i) begin
    if (rst_i || preset) begin
        proto_r <= `TXT_PROTO_RESET;
    end else if (wr_proto) begin
        proto_r <= wb_dat_i[7:0];
    end
end

always @(posedge clk_i) begin
    if (rst_i || preset || wr_proto) begin
        timer_hi_r <= `TXT_TIMER_HI_RESET;
        timer_lo_r <= `TXT_TIMER_LO_RESET;
        pulse_r <= `TXT_PULSE_RESET;
    end else begin
        if (wr_hi) begin
            timer_hi_r <= wb_dat_i[7:0];
        end
        if (wr_lo) begin
            timer_lo_r <= wb_dat_i[7:0];
        end
        if (wr_pulse) begin
            pulse_r <= wb_dat_i[7:0];
        end
    end
end

// start event selection
wire [1:0] start_sel = timer_hi_r[`TXT_SEL_MSB:`TXT_SEL_LSB];
wire [13:0] delay_len = {timer_hi_r[`TXT_LEN_HI_MSB:0], timer_lo_r};
wire len_zero = (delay_len == 14'h0000);
reg start_evt;

always @* begin
    case (start_sel)
        `TXT_SEL_TX_BEGIN: begin
            start_evt = tx_sof_begin_i;
        end
        `TXT_SEL_TX_END: begin
            start_evt = tx_sof_end_i;
        end
        `TXT_SEL_RX_BEGIN: begin
            start_evt = rx_sof_begin_i;
        end
        `TXT_SEL_RX_END: begin
            start_evt = rx_sof_end_i;
        end
        default: begin
            start_evt = 1'b0;
        end
    endcase
end

// delay timer states
localparam ST_IDLE = 1'b0;
localparam ST_RUN = 1'b1;

reg state_r;
reg [4:0] pre_r;
reg [13:0] cnt_r;

always @(posedge clk_i) begin
    if (rst_i || preset || wr_proto) begin
        state_r <= ST_IDLE;
        pre_r <= 5'h00;
        cnt_r <= 14'h0000;
        tx_trigger_o <= 1'b0;
    end else begin
        tx_trigger_o <= 1'b0;
        if (start_evt && !len_zero) begin
            // a new start event restarts a running count
            state_r <= ST_RUN;
            pre_r <= TICK_LAST;
            cnt_r <= delay_len;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    pre_r <= 5'h00;
                end
                ST_RUN: begin
                    if (pre_r == 5'h00) begin
                        pre_r <= TICK_LAST;
                        if (cnt_r == 14'h0001) begin
                            state_r <= ST_IDLE;
                            tx_trigger_o <= 1'b1;
                        end
                        cnt_r <= cnt_r - 14'h0001;
                    end else begin
                        pre_r <= pre_r - 5'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        timer_busy_o <= 1'b0;
    end else begin
        timer_busy_o <= (state_r == ST_RUN) && !preset && !wr_proto;
    end
end

// pulse width selection, registered to break the multiply path
reg [9:0] width_r;
reg bypass_r;
wire [2:0] proto = proto_r[`TXT_PROTO_MSB:0];
// 255 steps of four cycles still fit the 10-bit width counter
wire [17:0] ovr_prod = pulse_r * STEP_CYC;

always @(posedge clk_i) begin
    if (rst_i || preset) begin
        width_r <= VIC_CYC;
        bypass_r <= 1'b0;
    end else if (pulse_r != `TXT_PULSE_RESET) begin
        width_r <= ovr_prod[9:0];
        bypass_r <= 1'b0;
    end else begin
        bypass_r <= 1'b0;
        case (proto)
            `TXT_PROTO_VIC: begin
                width_r <= VIC_CYC;
            end
            `TXT_PROTO_A106: begin
                width_r <= A106_CYC;
            end
            `TXT_PROTO_A212: begin
                width_r <= A212_CYC;
            end
            `TXT_PROTO_A424: begin
                width_r <= A424_CYC;
            end
            default: begin
                // no width control at 848 kbps and unlisted codes
                width_r <= 10'h000;
                bypass_r <= 1'b1;
            end
        endcase
    end
end

txt_pulse_gen u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(preset),
    .start_i(mod_req_i),
    .bypass_i(bypass_r),
    .level_i(mod_level_i),
    .width_i(width_r),
    .pulse_o(mod_pulse_o)
);

// high count byte is latched on a low byte read so the pair agrees
reg [5:0] cnt_hi_snap_r;

always @(posedge clk_i) begin
    if (rst_i) begin
        cnt_hi_snap_r <= 6'h00;
    end else if (rd && hit(idx, `TXT_IDX_COUNT_LO)) begin
        cnt_hi_snap_r <= cnt_r[13:8];
    end
end

// read data and ack; unmapped indices read zero and still ack
reg [7:0] rd_byte;

always @* begin
    rd_byte = 8'h00;
    if (hit(idx, `TXT_IDX_PROTO)) begin
        rd_byte = proto_r;
    end else if (hit(idx, `TXT_IDX_TIMER_HI)) begin
        rd_byte = timer_hi_r;
    end else if (hit(idx, `TXT_IDX_TIMER_LO)) begin
        rd_byte = timer_lo_r;
    end else if (hit(idx, `TXT_IDX_PULSE)) begin
        rd_byte = pulse_r;
    end else if (hit(idx, `TXT_IDX_STATUS)) begin
        rd_byte[`TXT_ST_RUN] = (state_r == ST_RUN);
        rd_byte[`TXT_ST_PULSE] = mod_pulse_o;
        rd_byte[`TXT_ST_EN] = en_r;
    end else if (hit(idx, `TXT_IDX_COUNT_LO)) begin
        rd_byte = cnt_r[7:0];
    end else if (hit(idx, `TXT_IDX_COUNT_HI)) begin
        rd_byte = {2'b00, cnt_hi_snap_r};
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= req;
        if (rd) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end
end

endmodule

// ---- sim/txt_rf_peer.sv ----
`timescale 1ns/100ps
// far side: raises one frame-start event and times each pulse
module txt_rf_peer (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic [1:0] code_i,
    input wire logic mod_pulse_i,
    output logic [3:0] ev_o,
    output logic [9:0] width_o
);
    logic [9:0] cnt_r = 10'h0;
    always @(posedge clk_i) begin
        ev_o <= fire_i ? 4'h1 << code_i : 4'h0;
        if (mod_pulse_i)
            cnt_r <= cnt_r + 10'h1;
        else if (cnt_r != 10'h0) begin
            width_o <= cnt_r;
            cnt_r <= 10'h0;
        end
    end
endmodule

// ---- sim/txt_delay_timer_chk.sv ----
`timescale 1ns/100ps
module txt_delay_timer_chk (
    input wire clk_i,
    input wire rst_i,
    input wire wb_stb_i,
    input wire wb_cyc_i,
    input wire wb_ack_o,
    input wire en_i,
    input wire tx_trigger_o,
    input wire timer_busy_o,
    input wire mod_pulse_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // enable passes four flops, so allow slack
    sequence s_off;
        !en_i [*7];
    endsequence
    property p_ack;
        s_req |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack1;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_ackc;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ackc: assert property (p_ackc) else $error("ack unasked");
    property p_rst;
        disable iff (1'h0)
        rst_i |=> !wb_ack_o && !tx_trigger_o && !timer_busy_o
            && !mod_pulse_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_trig1;
        tx_trigger_o |=> !tx_trigger_o;
    endproperty
    a_trig1: assert property (p_trig1) else $error("trig long");
    property p_trigb;
        tx_trigger_o |-> timer_busy_o && $past(timer_busy_o);
    endproperty
    a_trigb: assert property (p_trigb) else $error("trig idle");
    property p_early;
        $rose(timer_busy_o) |-> !tx_trigger_o [*8];
    endproperty
    a_early: assert property (p_early) else $error("trig early");
    property p_en;
        s_off |=> !timer_busy_o && !mod_pulse_o;
    endproperty
    a_en: assert property (p_en) else $error("enable low");
endmodule
bind txt_delay_timer txt_delay_timer_chk chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
    .wb_ack_o(wb_ack_o), .en_i(en_i), .tx_trigger_o(tx_trigger_o),
    .timer_busy_o(timer_busy_o), .mod_pulse_o(mod_pulse_o));

// ---- sim/tb_tx_delay_and_pulse_timing.sv ----
`timescale 1ns/100ps
`include "txt_regs.vh"
module tb_tx_delay_and_pulse_timing;
    localparam [5:0] hi = `TXT_IDX_TIMER_HI;
    localparam [5:0] lo = `TXT_IDX_TIMER_LO;
    localparam [5:0] pl = `TXT_IDX_PULSE;
    localparam [5:0] pr = `TXT_IDX_PROTO;
    logic clk_i = 1'h0, rst_i = 1'h1, we = 1'h0, stb = 1'h0, cyc = 1'h0;
    logic en = 1'h1, req = 1'h0, lvl = 1'h0, fire = 1'h0;
    logic ack, trig, busy, mpul;
    logic [1:0] code = 2'h0;
    logic [3:0] sel = 4'h0, ev;
    logic [7:0] adr = 8'h0;
    logic [9:0] width;
    logic [31:0] wd = 32'h0, rdat;
    int error_cnt = 0, n_compared = 0, t = 0, n;
    int ns_tab[4] = '{`TXT_VIC_NS, `TXT_A106_NS, `TXT_A212_NS, `TXT_A424_NS};
    txt_delay_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wd), .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb),
        .wb_cyc_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .en_i(en),
        .tx_sof_begin_i(ev[0]), .tx_sof_end_i(ev[1]),
        .rx_sof_begin_i(ev[2]), .rx_sof_end_i(ev[3]), .mod_req_i(req),
        .mod_level_i(lvl), .tx_trigger_o(trig), .timer_busy_o(busy),
        .mod_pulse_o(mpul));
    txt_rf_peer peer (.clk_i(clk_i), .fire_i(fire), .code_i(code),
        .mod_pulse_i(mpul), .ev_o(ev), .width_o(width));
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        t++;
        if (t == 40000) begin
            error_cnt++;
            end_sim;
        end
    end
    task end_sim;
        $display("errors %0d compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task bus(input [5:0] i, input [7:0] d, input w, input [3:0] s);
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        adr <= {i, 2'h0};
        wd <= {24'h0, d};
        we <= w;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1);
        chk(n, 2);
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task wr(input [5:0] i, input [7:0] d);
        bus(i, d, 1'h1, 4'h1);
    endtask
    task rd(input [5:0] i, input [7:0] e);
        bus(i, 8'h0, 1'h0, 4'hf);
        chk(rdat, {24'h0, e});
    endtask
    task fire_ev(input [1:0] c);
        @(posedge clk_i);
        fire <= 1'h1;
        code <= c;
        @(posedge clk_i);
        fire <= 1'h0;
    endtask
    // counts edges from the event pulse to the trigger
    task run(input [1:0] c, input int e);
        fire_ev(c);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (trig !== 1'h1 && n < 9000);
        chk(n, e);
    endtask
    task t_regs;
        rd(`TXT_IDX_STATUS, 8'h04);
        rd(hi, 8'hc2);
        rd(lo, 8'h00);
        rd(pl, 8'h00);
        wr(lo, 8'h5a);
        bus(lo, 8'ha5, 1'h1, 4'he);
        rd(lo, 8'h5a);
        rd(6'h3f, 8'h00);
        wr(hi, 8'h3f);
        wr(pl, 8'h07);
        wr(pr, 8'h01);
        rd(pr, 8'h01);
        rd(hi, 8'hc2);
        rd(lo, 8'h00);
        rd(pl, 8'h00);
    endtask
    task t_delay;
        for (int s = 0; s < 4; s++) begin
            wr(hi, {s[1:0], 6'h00});
            wr(lo, 8'h02);
            fire_ev(s[1:0] ^ 2'h1);
            repeat (3) @(posedge clk_i);
            #1;
            chk(busy, 1'h0);
            run(s[1:0], `TXT_TICK_CYC * 2 + 1);
        end
        wr(hi, 8'h01);
        wr(lo, 8'h00);
        run(2'h0, `TXT_TICK_CYC * 256 + 1);
        wr(hi, 8'hc0);
        run(2'h3, 9000);
    endtask
    task pulse(input [7:0] p, input [7:0] o, input int w);
        wr(pr, p);
        wr(pl, o);
        @(posedge clk_i);
        req <= 1'h1;
        @(posedge clk_i);
        req <= 1'h0;
        repeat (500) @(posedge clk_i);
        chk(width, w);
    endtask
    // no width control: pulse follows the level, one cycle late
    task t_bypass;
        wr(pr, 8'h04);
        @(posedge clk_i);
        lvl <= 1'h1;
        repeat (9) @(posedge clk_i);
        lvl <= 1'h0;
        repeat (4) @(posedge clk_i);
        chk(width, 32'h9);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (6) @(posedge clk_i);
        t_regs;
        t_delay;
        pulse(8'h00, 8'h02, `TXT_STEP_CYC * 2);
        for (int p = 0; p < 4; p++)
            pulse(p[7:0], 8'h00, `TXT_NS2CYC(ns_tab[p]));
        t_bypass;
        wr(hi, 8'h11);
        wr(pl, 8'h05);
        fire_ev(2'h0);
        rd(`TXT_IDX_STATUS, 8'h05);
        rd(`TXT_IDX_COUNT_LO, 8'h00);
        rd(`TXT_IDX_COUNT_HI, 8'h11);
        chk(busy, 1'h1);
        en <= 1'h0;
        repeat (8) @(posedge clk_i);
        chk(busy, 1'h0);
        wr(lo, 8'h33);
        rd(hi, 8'hc2);
        rd(lo, 8'h00);
        rd(pl, 8'h00);
        end_sim;
    end
endmodule
